// ==== common/mbs_defs.vh ====
// Constants for the serial/TCP coil-reading slave front end
`ifndef MBS_DEFS_VH
`define MBS_DEFS_VH
`define MBS_CLK_HZ      25000000
`define MBS_BAUD_SEL0   1200
`define MBS_BAUD_SEL1   2400
`define MBS_BAUD_SEL2   4800
`define MBS_BAUD_SEL3   9600
`define MBS_BAUD_SEL4   19200
`define MBS_BAUD_SEL5   38400
`define MBS_BAUD_SEL6   57600
`define MBS_BAUD_SEL7   115200
`define MBS_TCP_PORT    16'h01F6
`define MBS_REG_SERCFG  8'h00
`define MBS_REG_SLAVE   8'h04
`define MBS_REG_EXCST   8'h08
`define MBS_REG_STATUS  8'h0C
`define MBS_REG_PORT    8'h10
`define MBS_REG_COUNT   8'h14
`define MBS_CFG_DATA8   0
`define MBS_CFG_STOP2   1
`define MBS_CFG_PAR_LO  2
`define MBS_CFG_BAUD_LO 4
`define MBS_SERCFG_RST  7'h31
`define MBS_SLAVE_RST   7'h01
`define MBS_SLAVE_MIN   8'h01
`define MBS_SLAVE_MAX   8'h7F
`define MBS_FC_COILS    8'h01
`define MBS_FC_INPUTS   8'h02
`define MBS_FC_HOLD     8'h03
`define MBS_FC_INREG    8'h04
`define MBS_FC_WCOIL    8'h05
`define MBS_FC_EXCST    8'h06
`define MBS_EXC_FLAG    8'h80
`define MBS_EXC_FUNC    8'h01
`define MBS_EXC_ADDR    8'h02
`define MBS_EXC_DATA    8'h03
`define MBS_EXC_FAIL    8'h04
`define MBS_CRC_POLY    16'hA001
`define MBS_CRC_INIT    16'hFFFF
`define MBS_MBAP_LEN    5'h07
`define MBS_MAX_COILS   17'h00040
`define MBS_NUM_CONN    2'h3
`endif

// ==== design/mbs_crc16.v ====
// One-byte update of the reflected 16-bit frame check
`include "mbs_defs.vh"
module mbs_crc16 (
   input  wire [15:0] crc_in,
   input  wire [7:0]  data,
   output reg  [15:0] crc_out
);
   integer i;
   reg [15:0] c;
   always @* begin
      c = crc_in ^ {8'h00, data};
      for (i = 0; i < 8; i = i + 1) begin
         if (c[0])
            c = (c >> 1) ^ `MBS_CRC_POLY;
         else
            c = c >> 1;
      end
      crc_out = c;
   end
endmodule

// ==== design/mbs_coil_reader.v ====
// Slave front end: frame parse, address/function check, coil packing
//
// Notes on behaviour
// - serial format configurable: 7/8 data bits, 1/2 stop, none/odd/even.
// - bit rate selectable 1200..115200 baud, 9600 after reset.
// - TCP listen port 502, same register map as serial.
// - up to three TCP connections, each with its own context.
// - serial frames start with slave address, configurable 1..127.
// - broadcast zero and addresses 128..247 never taken as own.
// - slave address checked only on serial frames, not TCP.
// - TCP frames start with 7-byte header: tid, pid zero, length, unit.
// - TCP reply echoes tid and unit id; unit id ignored otherwise.
// - function codes 0x01..0x06 accepted.
// - unsupported function code answered with illegal-function exception.
// - serial frames end with 16-bit CRC; TCP frames carry none.
// - codes 0x01 and 0x02 both return output status, echo code.
// - output addresses zero-based: output n is address n-1.
// - status bit 1 means active, 0 inactive.
// - first output in bit 0 of first byte, filling upward.
// - unused high bits of last data byte are zero.
// - byte count is quantity/8 rounded up; that many bytes follow.
// - exception codes 01 function, 02 address, 03 data, 04 failure.
// - reported state is logical, independent of contact polarity.
`include "mbs_defs.vh"
module mbs_coil_reader (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // APB register port
   input  wire [7:0]  paddr,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Request byte stream from UART or TCP stack
   input  wire        rx_valid,
   input  wire [7:0]  rx_data,
   input  wire        rx_last,
   input  wire        rx_tcp,
   input  wire [1:0]  rx_conn,
   output reg         rx_ready,
   // Reply byte stream
   output reg         tx_valid,
   output reg  [7:0]  tx_data,
   output reg         tx_last,
   output reg         tx_tcp,
   output reg  [1:0]  tx_conn,
   input  wire        tx_ready,
   // Logical output states, bit n is output address n
   input  wire [63:0] coil_state,
   // Serial port and TCP settings
   output reg         ser_data8,
   output reg         ser_stop2,
   output reg  [1:0]  ser_parity,
   output reg  [15:0] ser_baud_div,
   output reg  [15:0] tcp_port
);
   localparam [1:0] S_RX    = 2'h0;
   localparam [1:0] S_CHECK = 2'h1;
   localparam [1:0] S_TX    = 2'h2;

   reg  [1:0]  state;
   reg  [6:0]  sercfg;
   reg  [6:0]  slave_addr;
   reg  [7:0]  excst;
   reg  [7:0]  last_exc;
   reg  [15:0] frame_cnt;
   reg  [15:0] crc_err_cnt;
   // Receive side
   reg  [4:0]  pos;
   reg  [4:0]  nbytes;
   reg         f_tcp;
   reg  [1:0]  f_conn;
   reg  [7:0]  f_addr;
   reg         f_pid_nz;
   reg  [7:0]  f_fc;
   reg  [15:0] f_start;
   reg  [15:0] f_qty;
   reg  [15:0] crc_rx;
   reg  [15:0] ctx_tid [0:2];
   reg  [7:0]  ctx_uid [0:2];
   // Reply side
   reg  [7:0]  r_fc;
   reg  [7:0]  r_exc;
   reg  [3:0]  r_count;
   reg  [3:0]  r_pdulen;
   reg  [4:0]  ti;
   reg  [7:0]  bitpos;
   reg  [6:0]  remain;
   reg  [15:0] crc_tx;
   // Combinational helpers
   reg  [31:0] div32;
   reg  [31:0] rd;
   reg         rd_ok;
   reg  [7:0]  next_tx;
   reg         data_byte;
   reg  [63:0] shifted;
   integer     k;

   wire        cur_tcp  = (pos == 5'h00) ? rx_tcp : f_tcp;
   wire [1:0]  cur_conn = (pos == 5'h00) ? rx_conn : f_conn;
   wire [4:0]  hdr_len  = cur_tcp ? `MBS_MBAP_LEN : 5'h01;
   wire [4:0]  pi       = pos - hdr_len;
   wire        in_pdu   = (pos >= hdr_len);
   wire        rx_take  = rx_valid & rx_ready;
   wire [4:0]  r_hl     = tx_tcp ? `MBS_MBAP_LEN : 5'h01;
   wire [4:0]  total    = r_hl + {1'b0, r_pdulen} +
                          (tx_tcp ? 5'h00 : 5'h02);
   wire [4:0]  tp       = ti - r_hl;
   wire [16:0] span     = {1'b0, f_start} + {1'b0, f_qty};
   wire [15:0] crc_rx_n;
   wire [15:0] crc_tx_n;
   wire        apb_wr   = psel & penable & pready & pwrite;

   mbs_crc16 u_crc_rx (
      .crc_in  ((pos == 5'h00) ? `MBS_CRC_INIT : crc_rx),
      .data    (rx_data),
      .crc_out (crc_rx_n)
   );

   mbs_crc16 u_crc_tx (
      .crc_in  (crc_tx),
      .data    (next_tx),
      .crc_out (crc_tx_n)
   );

   // Baud divisor lookup from the select field
   always @* begin
      case (sercfg[6:4])
         3'h0:    div32 = `MBS_CLK_HZ / `MBS_BAUD_SEL0;
         3'h1:    div32 = `MBS_CLK_HZ / `MBS_BAUD_SEL1;
         3'h2:    div32 = `MBS_CLK_HZ / `MBS_BAUD_SEL2;
         3'h3:    div32 = `MBS_CLK_HZ / `MBS_BAUD_SEL3;
         3'h4:    div32 = `MBS_CLK_HZ / `MBS_BAUD_SEL4;
         3'h5:    div32 = `MBS_CLK_HZ / `MBS_BAUD_SEL5;
         3'h6:    div32 = `MBS_CLK_HZ / `MBS_BAUD_SEL6;
         default: div32 = `MBS_CLK_HZ / `MBS_BAUD_SEL7;
      endcase
   end

   // Register read mux
   always @* begin
      rd    = 32'h00000000;
      rd_ok = 1'b1;
      case (paddr)
         `MBS_REG_SERCFG: rd = {25'h0000000, sercfg};
         `MBS_REG_SLAVE:  rd = {25'h0000000, slave_addr};
         `MBS_REG_EXCST:  rd = {24'h000000, excst};
         `MBS_REG_STATUS: rd = {23'h000000, (state != S_RX), last_exc};
         `MBS_REG_PORT:   rd = {16'h0000, `MBS_TCP_PORT};
         `MBS_REG_COUNT:  rd = {crc_err_cnt, frame_cnt};
         default:         rd_ok = 1'b0;
      endcase
   end

   // Next reply byte, indexed by ti
   always @* begin
      next_tx   = 8'h00;
      data_byte = 1'b0;
      shifted   = coil_state >> bitpos;
      if (tx_tcp && ti < `MBS_MBAP_LEN) begin
         case (ti)
            5'h00:   next_tx = ctx_tid[tx_conn][15:8];
            5'h01:   next_tx = ctx_tid[tx_conn][7:0];
            5'h05:   next_tx = {4'h0, r_pdulen} + 8'h01;
            5'h06:   next_tx = ctx_uid[tx_conn];
            default: next_tx = 8'h00;
         endcase
      end else if (!tx_tcp && ti == 5'h00) begin
         next_tx = {1'b0, slave_addr};
      end else if (!tx_tcp && ti == total - 5'h02) begin
         next_tx = crc_tx[7:0];
      end else if (!tx_tcp && ti == total - 5'h01) begin
         next_tx = crc_tx[15:8];
      end else if (tp == 5'h00) begin
         next_tx = (r_exc != 8'h00) ? (r_fc | `MBS_EXC_FLAG) : r_fc;
      end else if (tp == 5'h01) begin
         if (r_exc != 8'h00)
            next_tx = r_exc;
         else if (r_fc == `MBS_FC_EXCST)
            next_tx = excst;
         else
            next_tx = {4'h0, r_count};
      end else begin
         data_byte = 1'b1;
         // Bits past the quantity read as zero
         for (k = 0; k < 8; k = k + 1)
            next_tx[k] = shifted[k] & (k < remain);
      end
   end

   // APB slave: answer in the first access cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= 32'h00000000;
         sercfg     <= `MBS_SERCFG_RST;
         slave_addr <= `MBS_SLAVE_RST;
         excst      <= 8'h00;
      end else begin
         pready  <= psel & ~penable;
         // Error flag stands only with pready, like the answer itself
         pslverr <= psel & ~penable & ~rd_ok;
         if (psel & ~penable)
            prdata <= pwrite ? 32'h00000000 : rd;
         if (apb_wr && paddr == `MBS_REG_SERCFG)
            sercfg <= pwdata[6:0];
         // Out-of-range addresses are refused
         if (apb_wr && paddr == `MBS_REG_SLAVE &&
             pwdata[31:0] >= {24'h000000, `MBS_SLAVE_MIN} &&
             pwdata[31:0] <= {24'h000000, `MBS_SLAVE_MAX})
            slave_addr <= pwdata[6:0];
         if (apb_wr && paddr == `MBS_REG_EXCST)
            excst <= pwdata[7:0];
      end
   end

   // Settings driven out from flops
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ser_data8    <= 1'b1;
         ser_stop2    <= 1'b0;
         ser_parity   <= 2'h0;
         ser_baud_div <= 16'h0000;
         tcp_port     <= 16'h0000;
      end else begin
         ser_data8    <= sercfg[`MBS_CFG_DATA8];
         ser_stop2    <= sercfg[`MBS_CFG_STOP2];
         ser_parity   <= sercfg[`MBS_CFG_PAR_LO +: 2];
         ser_baud_div <= div32[15:0];
         tcp_port     <= `MBS_TCP_PORT;
      end
   end

   // Frame engine
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= S_RX;
         rx_ready    <= 1'b0;
         pos         <= 5'h00;
         nbytes      <= 5'h00;
         f_tcp       <= 1'b0;
         f_conn      <= 2'h0;
         f_addr      <= 8'h00;
         f_pid_nz    <= 1'b0;
         f_fc        <= 8'h00;
         f_start     <= 16'h0000;
         f_qty       <= 16'h0000;
         crc_rx      <= 16'h0000;
         ctx_tid[0]  <= 16'h0000;
         ctx_tid[1]  <= 16'h0000;
         ctx_tid[2]  <= 16'h0000;
         ctx_uid[0]  <= 8'h00;
         ctx_uid[1]  <= 8'h00;
         ctx_uid[2]  <= 8'h00;
         r_fc        <= 8'h00;
         r_exc       <= 8'h00;
         r_count     <= 4'h0;
         r_pdulen    <= 4'h0;
         ti          <= 5'h00;
         bitpos      <= 8'h00;
         remain      <= 7'h00;
         crc_tx      <= 16'h0000;
         last_exc    <= 8'h00;
         frame_cnt   <= 16'h0000;
         crc_err_cnt <= 16'h0000;
         tx_valid    <= 1'b0;
         tx_data     <= 8'h00;
         tx_last     <= 1'b0;
         tx_tcp      <= 1'b0;
         tx_conn     <= 2'h0;
      end else begin
         case (state)
            S_RX: begin
               rx_ready <= 1'b1;
               if (rx_take) begin
                  f_tcp  <= cur_tcp;
                  f_conn <= cur_conn;
                  crc_rx <= crc_rx_n;
                  if (pos != 5'h1F)
                     pos <= pos + 5'h01;
                  if (!cur_tcp && pos == 5'h00)
                     f_addr <= rx_data;
                  if (pos == 5'h00)
                     f_pid_nz <= 1'b0;
                  // Header fields, kept per connection
                  if (cur_tcp && cur_conn < `MBS_NUM_CONN) begin
                     if (pos == 5'h00)
                        ctx_tid[cur_conn][15:8] <= rx_data;
                     if (pos == 5'h01)
                        ctx_tid[cur_conn][7:0] <= rx_data;
                     if (pos == 5'h06)
                        ctx_uid[cur_conn] <= rx_data;
                  end
                  if (cur_tcp && (pos == 5'h02 || pos == 5'h03) &&
                      rx_data != 8'h00)
                     f_pid_nz <= 1'b1;
                  // Fields arrive high byte first
                  if (in_pdu) begin
                     case (pi)
                        5'h00:   f_fc <= rx_data;
                        5'h01:   f_start[15:8] <= rx_data;
                        5'h02:   f_start[7:0] <= rx_data;
                        5'h03:   f_qty[15:8] <= rx_data;
                        5'h04:   f_qty[7:0] <= rx_data;
                        default: f_fc <= f_fc;
                     endcase
                  end
                  if (rx_last) begin
                     nbytes   <= pos + 5'h01;
                     pos      <= 5'h00;
                     rx_ready <= 1'b0;
                     state    <= S_CHECK;
                  end
               end
            end
            S_CHECK: begin
               r_fc    <= f_fc;
               r_exc   <= 8'h00;
               r_count <= f_qty[6:3] + {3'h0, (f_qty[2:0] != 3'h0)};
               // Output n is requested as start n-1
               bitpos  <= f_start[7:0];
               remain  <= f_qty[6:0];
               crc_tx  <= `MBS_CRC_INIT;
               tx_tcp  <= f_tcp;
               tx_conn <= f_conn;
               ti      <= 5'h00;
               state   <= S_RX;
               // Bad check value drops the frame
               if (!f_tcp && crc_rx != 16'h0000) begin
                  crc_err_cnt <= crc_err_cnt + 16'h0001;
               // Only our own address, never 0 or 128..247
               end else if (!f_tcp && (nbytes < 5'h04 ||
                            f_addr != {1'b0, slave_addr})) begin
                  state <= S_RX;
               end else if (f_tcp && (f_pid_nz || nbytes < 5'h08 ||
                            f_conn >= `MBS_NUM_CONN)) begin
                  state <= S_RX;
               end else begin
                  frame_cnt <= frame_cnt + 16'h0001;
                  state     <= S_TX;
                  r_pdulen  <= 4'h2;
                  case (f_fc)
                     `MBS_FC_COILS, `MBS_FC_INPUTS: begin
                        // Order of checks: length, quantity, address
                        if (nbytes < hdr_len_of(f_tcp) + 5'h05 ||
                            f_qty == 16'h0000 ||
                            {1'b0, f_qty} > `MBS_MAX_COILS) begin
                           r_exc <= `MBS_EXC_DATA;
                        end else if (span > `MBS_MAX_COILS) begin
                           r_exc <= `MBS_EXC_ADDR;
                        end else begin
                           r_pdulen <= 4'h2 + f_qty[6:3] +
                                       {3'h0, (f_qty[2:0] != 3'h0)};
                        end
                     end
                     `MBS_FC_EXCST: r_pdulen <= 4'h2;
                     // Not served here: answered with the failure exception
                     `MBS_FC_HOLD, `MBS_FC_INREG, `MBS_FC_WCOIL:
                        r_exc <= `MBS_EXC_FAIL;
                     default: r_exc <= `MBS_EXC_FUNC;
                  endcase
               end
            end
            S_TX: begin
               if (!tx_valid || tx_ready) begin
                  if (ti == total) begin
                     tx_valid <= 1'b0;
                     tx_last  <= 1'b0;
                     last_exc <= r_exc;
                     state    <= S_RX;
                  end else begin
                     tx_valid <= 1'b1;
                     tx_data  <= next_tx;
                     tx_last  <= (ti == total - 5'h01);
                     ti       <= ti + 5'h01;
                     if (!tx_tcp && ti < total - 5'h02)
                        crc_tx <= crc_tx_n;
                     if (data_byte) begin
                        bitpos <= bitpos + 8'h08;
                        remain <= (remain > 7'h08) ? remain - 7'h08
                                                   : 7'h00;
                     end
                  end
               end
            end
            default: state <= S_RX;
         endcase
      end
   end

   // Header length of the frame type
   function [4:0] hdr_len_of;
      input t;
      begin
         hdr_len_of = t ? `MBS_MBAP_LEN : 5'h01;
      end
   endfunction

   // coil_state already holds logical levels
endmodule

// ==== verif/mbs_chk_chk.sv ====
// Port timing checker for the coil reader front end
module mbs_chk (
   // Clock and reset
   input wire        clk,
   input wire        rst_n,
   // Register port
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   input wire [31:0] prdata,
   // Request and reply streams
   input wire        rx_valid,
   input wire        rx_ready,
   input wire        rx_last,
   input wire        tx_valid,
   input wire        tx_ready,
   input wire [7:0]  tx_data,
   input wire        tx_last,
   // Fixed settings
   input wire [15:0] tcp_port
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_apb_zero_wait: assert property (psel && !penable |=> pready)
      else $error("pready missing in first access cycle");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("pslverr without pready or with data");
   a_port_fixed: assert property ($past(rst_n) |-> tcp_port == 16'h01F6)
      else $error("listen port not 502");
   a_tx_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("reply byte changed before acceptance");
   a_rx_closed: assert property (rx_valid && rx_ready && rx_last |=> !rx_ready)
      else $error("request stream open after frame end");
   a_reply_gap: assert property (rx_valid && rx_ready && rx_last |=>
      !tx_valid [*2])
      else $error("reply started before check cycle");
   a_rx_reopen: assert property (tx_valid && tx_ready && tx_last |=>
      !tx_valid ##1 rx_ready)
      else $error("request stream not reopened after reply");
   a_no_overlap: assert property (rx_ready |-> !tx_valid)
      else $error("reply while accepting requests");
endmodule

bind mbs_coil_reader mbs_chk u_mbs_chk (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_last(rx_last),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
   .tx_last(tx_last), .tcp_port(tcp_port));

// ==== verif/mbs_master.sv ====
// Polling master model on the request and reply byte streams
module mbs_master (
   // Clock
   input  wire        clk,
   // Request stream
   output logic       rx_valid,
   output logic [7:0] rx_data,
   output logic       rx_last,
   output logic       rx_tcp,
   output logic [1:0] rx_conn,
   input  wire        rx_ready,
   // Reply stream
   input  wire        tx_valid,
   input  wire [7:0]  tx_data,
   input  wire        tx_last,
   input  wire        tx_tcp,
   input  wire [1:0]  tx_conn,
   output logic       tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] req[$];
   logic [7:0] rsp[$];
   logic       slow = 1'b0;
   logic       got_tcp;
   logic [1:0] got_conn;
   int         tmo = 0;

   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      rx_last  = 1'b0;
      rx_tcp   = 1'b0;
      rx_conn  = 2'h0;
      tx_ready = 1'b1;
   end

   // Whole frame out, then gather the reply within wait_n cycles
   task automatic xfer(input logic tcp, input logic [1:0] conn,
                       input int wait_n);
      int i;
      int n;
      rsp.delete();
      for (i = 0; i < req.size(); i++) begin
         rx_valid <= 1'b1;
         rx_data  <= req[i];
         rx_last  <= (i == req.size() - 1);
         rx_tcp   <= tcp;
         rx_conn  <= conn;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (rx_ready !== 1'b1 && n < 200);
         if (n >= 200) tmo++;
      end
      // Released line shows no stale byte
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
      rx_last  <= 1'b0;
      n = 0;
      while (n < wait_n) begin
         @(posedge clk);
         n++;
         if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (rsp.size() == 0) begin
               got_tcp  = tx_tcp;
               got_conn = tx_conn;
            end
            rsp.push_back(tx_data);
            if (tx_last === 1'b1) n = wait_n;
         end
         tx_ready <= slow ? ~tx_ready : 1'b1;
      end
   endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the coil reader front end
`include "mbs_defs.vh"
`define CHK(nm, e, g) begin \
   n_checks++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
   end \
end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd;
   wire  [31:0] prdata;
   wire         pready, pslverr, rx_valid, rx_last, rx_tcp, rx_ready;
   wire  [7:0]  rx_data, tx_data;
   wire  [1:0]  rx_conn, tx_conn, ser_parity;
   wire         tx_valid, tx_last, tx_tcp, tx_ready, ser_data8, ser_stop2;
   wire  [15:0] ser_baud_div, tcp_port;
   logic [63:0] coil_state;
   logic        err;
   int          fail_count, n_checks, seed, n_rep, n_crc, i, k, st, qt;
   logic [7:0]  pdu[$], rp[$], ex[$], excst, slave;
   logic [7:0]  fcs[9] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h41,
                           8'h01, 8'h01, 8'h02};
   logic [7:0]  sts[9] = '{0, 0, 0, 0, 0, 0, 0, 60, 0};
   logic [7:0]  qts[9] = '{1, 1, 1, 1, 1, 1, 0, 8, 65};

   mbs_coil_reader u_mbs_coil_reader (.clk(clk), .rst_n(rst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .rx_tcp(rx_tcp), .rx_conn(rx_conn),
      .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_tcp(tx_tcp), .tx_conn(tx_conn),
      .tx_ready(tx_ready), .coil_state(coil_state),
      .ser_data8(ser_data8), .ser_stop2(ser_stop2),
      .ser_parity(ser_parity), .ser_baud_div(ser_baud_div),
      .tcp_port(tcp_port));
   mbs_master u_mbs_master (.clk(clk), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .rx_tcp(rx_tcp),
      .rx_conn(rx_conn), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_tcp(tx_tcp),
      .tx_conn(tx_conn), .tx_ready(tx_ready));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic results;
      if (fail_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         results();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      int          j, b;
      c = `MBS_CRC_INIT;
      for (j = 0; j < q.size(); j++) begin
         c = c ^ {8'h00, q[j]};
         for (b = 0; b < 8; b++)
            c = c[0] ? (c >> 1) ^ `MBS_CRC_POLY : c >> 1;
      end
      return c;
   endfunction

   // Expected reply PDU for the request in pdu
   task automatic model;
      int s, q, b;
      rp.delete();
      s = (pdu.size() > 2) ? {pdu[1], pdu[2]} : 0;
      q = (pdu.size() > 4) ? {pdu[3], pdu[4]} : 0;
      if (pdu[0] == 8'h01 || pdu[0] == 8'h02) begin
         if (q == 0 || q > 64)
            rp = '{pdu[0] | 8'h80, 8'h03};
         else if (s + q > 64)
            rp = '{pdu[0] | 8'h80, 8'h02};
         else begin
            rp = '{pdu[0], 8'((q + 7) / 8)};
            for (b = 0; b < (q + 7) / 8 * 8; b++) begin
               if (b % 8 == 0) rp.push_back(8'h00);
               if (b < q) rp[rp.size() - 1][b % 8] = coil_state[s + b];
            end
         end
      end else if (pdu[0] >= 8'h03 && pdu[0] <= 8'h05)
         rp = '{pdu[0] | 8'h80, 8'h04};
      else if (pdu[0] == 8'h06)
         rp = '{8'h06, excst};
      else
         rp = '{pdu[0] | 8'h80, 8'h01};
   endtask

   // Over TCP, ad is the low protocol id byte; bad_crc spoils serial check
   task automatic frame(input logic tcp, input logic [1:0] conn,
                        input logic [7:0] ad, input logic bad_crc);
      logic [15:0] c;
      logic [7:0]  hd[$];
      model();
      if (tcp) begin
         hd = '{8'($random(seed)), 8'($random(seed)), 8'h00, ad, 8'h00,
                8'(pdu.size() + 1), 8'($random(seed))};
         u_mbs_master.req = {hd, pdu};
         ex = {hd[0:1], 8'h00, 8'h00, 8'h00, 8'(rp.size() + 1), hd[6], rp};
      end else begin
         u_mbs_master.req = {ad, pdu};
         c = crc16(u_mbs_master.req);
         u_mbs_master.req.push_back(c[7:0] ^ {7'h00, bad_crc});
         u_mbs_master.req.push_back(c[15:8]);
         ex = {ad, rp};
         c = crc16(ex);
         ex = {ex, c[7:0], c[15:8]};
      end
      if (bad_crc || (!tcp && ad != slave) || (tcp && (ad || conn == 2'h3)))
         ex.delete();
      else
         n_rep++;
      if (!tcp && bad_crc) n_crc++;
      u_mbs_master.xfer(tcp, conn, ex.size() ? 300 : 30);
      if (u_mbs_master.tmo) begin
         fail_count++;
         results();
      end
      `CHK("reply len", ex.size(), u_mbs_master.rsp.size())
      for (k = 0; k < ex.size() && k < u_mbs_master.rsp.size(); k++)
         `CHK("reply byte", ex[k], u_mbs_master.rsp[k])
      if (ex.size() && tcp)
         `CHK("reply conn", {1'b1, conn},
              {u_mbs_master.got_tcp, u_mbs_master.got_conn})
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      results();
   end

   initial begin
      seed = 32'hC8955CDE;
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      coil_state = 64'h0;
      slave = 8'h01;
      excst = 8'h00;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("baud div", 16'h0A2C, ser_baud_div)
      `CHK("tcp port", 16'h01F6, tcp_port)
      `CHK("format", 4'h1, {ser_parity, ser_stop2, ser_data8})
      apb(1'b0, `MBS_REG_SERCFG, 32'h0);
      `CHK("sercfg", 32'h31, rd)
      apb(1'b0, `MBS_REG_PORT, 32'h0);
      `CHK("port reg", 32'h1F6, rd)
      apb(1'b0, 8'h18, 32'h0);
      `CHK("unmapped", 1'b1, err)
      apb(1'b1, `MBS_REG_SLAVE, 32'h80);
      apb(1'b0, `MBS_REG_SLAVE, 32'h0);
      `CHK("slave", 32'h01, rd)
      slave = 8'h7F;
      apb(1'b1, `MBS_REG_SLAVE, 32'h7F);
      excst = 8'($random(seed));
      apb(1'b1, `MBS_REG_EXCST, {24'h0, excst});
      for (i = 0; i < 16; i++) begin
         coil_state <= {$random(seed), $random(seed)};
         st = i < 2 ? 2 - 2 * i : {$random(seed)} % 64;
         qt = i == 0 ? 13 : i == 1 ? 64 : 1 + {$random(seed)} % (64 - st);
         pdu = '{8'(1 + i % 2), 8'h00, 8'(st), 8'h00, 8'(qt)};
         u_mbs_master.slow <= (i % 3 == 0);
         @(posedge clk);
         frame(i % 4 == 3, 2'(i % 3), i % 4 == 3 ? 8'h00 : slave, 1'b0);
      end
      for (i = 0; i < 9; i++) begin
         pdu = '{fcs[i], 8'h00, sts[i], 8'h00, qts[i]};
         if (fcs[i] == 8'h06) pdu = '{8'h06};
         frame(i % 2, 2'(i % 3), i % 2 ? 8'h00 : slave, 1'b0);
      end
      pdu = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h08};
      frame(1'b0, 2'h0, 8'h7E, 1'b0);
      frame(1'b0, 2'h0, 8'h00, 1'b0);
      frame(1'b0, 2'h0, slave, 1'b1);
      frame(1'b1, 2'h0, 8'h01, 1'b0);
      frame(1'b1, 2'h3, 8'h00, 1'b0);
      frame(1'b1, 2'h2, 8'h00, 1'b0);
      apb(1'b0, `MBS_REG_COUNT, 32'h0);
      `CHK("count", {16'(n_crc), 16'(n_rep)}, rd)
      // Select 115200, even parity, two stops, seven data bits
      apb(1'b1, `MBS_REG_SERCFG, 32'h7A);
      repeat (2) @(posedge clk);
      `CHK("baud max", 16'h00D9, ser_baud_div)
      `CHK("format 7E2", 4'hA, {ser_parity, ser_stop2, ser_data8})
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("baud again", 16'h0A2C, ser_baud_div)
      results();
   end
endmodule
